// [umd_pkg.sv]
package umd_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] UMD_OFS_RHR = 4'h0;  // Read pops, divisor low when latch open
  localparam logic [3:0] UMD_OFS_IMASK = 4'h1;  // Divisor high when latch open
  localparam logic [3:0] UMD_OFS_FCR = 4'h2;  // Fraction and mode when latch open
  localparam logic [3:0] UMD_OFS_LCR = 4'h3;
  localparam logic [3:0] UMD_OFS_MSR = 4'h4;
  localparam logic [3:0] UMD_OFS_LSR = 4'h5;
  localparam logic [3:0] UMD_OFS_EFR = 4'h6;
  localparam logic [3:0] UMD_OFS_SLAVE = 4'h7;
  localparam logic [3:0] UMD_OFS_TRIG = 4'h8;
  localparam logic [3:0] UMD_OFS_EVT = 4'h9;  // Event flags, read clears Xoff flag only
  localparam logic [3:0] UMD_OFS_XOFF1 = 4'hA;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int UMD_LCR_DLAB = 7;
  localparam int UMD_FRAC_POL = 7;
  localparam int UMD_FRAC_MDROP = 6;
  localparam int UMD_FRAC_XPAR = 5;
  localparam int UMD_FRAC_FIR = 4;
  localparam int UMD_EFR_SCD = 5;
  localparam int UMD_EFR_ENH = 4;
  localparam int UMD_MSR_RXDIS = 2;
  localparam int UMD_FCR_EN = 0;
  localparam int UMD_IM_RX = 0;
  localparam int UMD_IM_LS = 2;
  localparam int UMD_IM_MS = 3;
  localparam int UMD_IM_XOFF = 5;
  localparam int UMD_IM_RTS = 6;
  localparam int UMD_IM_CTS = 7;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [7:0] UMD_RST_BYTE = 8'h00;
  localparam logic [7:0] UMD_RST_TRIG = 8'h01;
  localparam logic [7:0] UMD_IM_EFR_MASK = 8'hE0;  // Enable bits needing enhanced mode
  localparam logic [7:0] UMD_IM_RSVD = 8'h10;
  localparam int UMD_DEPTH = 256;
  localparam int UMD_AW = 8;
  localparam logic [8:0] UMD_CNT_ONE = 9'h001;
  localparam logic [8:0] UMD_CNT_FULL = 9'h100;
  localparam logic [3:0] UMD_IR_SLOW = 4'h3;  // Sixteenths of a bit
  localparam logic [3:0] UMD_IR_FAST = 4'h4;

  // Character leaving the receive shift register
  typedef struct packed {
    logic brk;
    logic ferr;
    logic par;
    logic [7:0] data;
  } umd_rx_char_t;

  // Receive FIFO entry
  typedef struct packed {
    logic brk;
    logic ferr;
    logic perr;
    logic [7:0] data;
  } umd_fifo_ent_t;

  // Divisor and fraction settings to the baud generator
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic [3:0] frac;
  } umd_baud_cfg_t;

  // Interrupt requests, each already masked
  typedef struct packed {
    logic line_status;
    logic rx_ready;
    logic modem;
    logic xoff;
    logic rts;
    logic cts;
  } umd_irq_t;

endpackage

// [umd_rx_ctrl.sv]
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - Multidrop on, special detect off: normal multidrop
// - Disabled receiver drops data until software clears the disable bit
// - Address byte flags parity error, interrupts, queued
// - Enabled: accept data, interrupt each address
// - Multidrop on, special detect on: auto address
// - Auto mode compares addresses, discards when unselected
// - Match enables receiver, queues address, interrupts
// - Mismatch while selected disables receiver
// - Divisor registers reachable only with latch bit
// - Polarity bit sets direction output level
// - Parity-errored flow characters optionally ignored
// - IR pulse three sixteenths or quarter bit
// - Receive interrupt follows FIFO trigger level
// - Data ready sets on push, clears empty
// - FIFO on, low enables clear: polled mode
// - Line status bits report overrun, errors, empties
// - Mask bit 7: interrupt on CTS rising
// - Mask bit 6: interrupt on RTS rising
// - Mask bit 5: Xoff interrupt, bit 4 reserved
// - Mask bit 3: modem delta interrupt
module umd_rx_ctrl
  import umd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rx_valid,
  input wire umd_rx_char_t rx_char,
  input wire logic thr_empty,
  input wire logic tsr_empty,
  input wire logic tx_active,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic [3:0] modem_delta,
  output umd_baud_cfg_t baud_cfg,
  output logic rs485_dir,
  output logic [3:0] ir_pulse_16ths,
  output logic xoff_event,
  output logic polled_mode,
  output umd_irq_t irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [UMD_AW-1:0] ptr_inc(input logic [UMD_AW-1:0] p);
    ptr_inc = p + {{(UMD_AW-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic ent_bad(input umd_fifo_ent_t e);
    ent_bad = e.brk | e.ferr | e.perr;
  endfunction

  logic [7:0] div_low_q, div_high_q, frac_q, imask_q, lcr_q, efr_q;
  logic [7:0] slave_q, trig_q, xoff1_q;
  logic fifo_en_q, rx_dis_q, overrun_q, ls_flag_q, xoff_flag_q;
  logic cts_flag_q, rts_flag_q;
  logic [3:0] delta_q;
  logic [2:0] cts_sync_q;
  logic cts_prev_q, rts_prev_q;
  umd_fifo_ent_t mem_q [UMD_DEPTH];
  logic [UMD_AW-1:0] wptr_q, rptr_q;
  logic [8:0] count_q, err_cnt_q;
  logic [8:0] cap;
  logic dlab, mdrop, auto_mode, norm_mode, is_addr, match;
  logic push, pop, full, empty, head_bad_next;
  logic wr_fire, rd_fire, rd_lsr, rd_msr, rd_evt;
  logic rx_dis_set, rx_dis_clr;
  umd_fifo_ent_t new_ent, head;

  // ****************************************
  // Decode
  // ****************************************
  // Strobes frozen with clock enable
  assign wr_fire = ce & wr;
  assign rd_fire = ce & rd;
  assign dlab = lcr_q[UMD_LCR_DLAB];
  assign rd_lsr = rd_fire & (addr == UMD_OFS_LSR);
  assign rd_msr = rd_fire & (addr == UMD_OFS_MSR);
  assign rd_evt = rd_fire & (addr == UMD_OFS_EVT);
  assign pop = rd_fire & (addr == UMD_OFS_RHR) & ~dlab & ~empty;

  // Mode selection
  assign mdrop = frac_q[UMD_FRAC_MDROP];
  assign norm_mode = mdrop & ~efr_q[UMD_EFR_SCD];
  assign auto_mode = mdrop & efr_q[UMD_EFR_SCD];
  assign is_addr = rx_char.par;
  assign match = is_addr & (rx_char.data == slave_q);

  // ****************************************
  // Receive acceptance
  // ****************************************
  // Push decision per mode
  always_comb begin
    push = 1'b0;
    rx_dis_set = 1'b0;
    rx_dis_clr = 1'b0;
    new_ent.data = rx_char.data;
    new_ent.brk = rx_char.brk;
    new_ent.ferr = rx_char.ferr;
    new_ent.perr = rx_char.par;
    if (rx_valid & ce) begin
      if (norm_mode) begin
        push = is_addr | ~rx_dis_q;
      end else if (auto_mode) begin
        if (match) begin
          push = 1'b1;
          rx_dis_clr = 1'b1;
        end else if (is_addr) begin
          rx_dis_set = 1'b1;
        end else begin
          push = ~rx_dis_q;
        end
      end else begin
        push = 1'b1;
      end
    end
  end

  // ****************************************
  // Receive FIFO
  // ****************************************
  // One entry deep with FIFO off
  assign cap = fifo_en_q ? UMD_CNT_FULL : UMD_CNT_ONE;
  assign full = (count_q >= cap);
  assign empty = (count_q == '0);
  assign head = mem_q[rptr_q];
  assign head_bad_next = (count_q > UMD_CNT_ONE) & ent_bad(mem_q[ptr_inc(rptr_q)]);

  // Storage
  always_ff @(posedge clk) begin
    if (push & ~full) begin
      mem_q[wptr_q] <= new_ent;
    end
  end

  // Pointers and counts
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      err_cnt_q <= '0;
    end else if (wr_fire & ~dlab & (addr == UMD_OFS_FCR) & wdata[1]) begin
      // Receive FIFO reset
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      err_cnt_q <= '0;
    end else begin
      if (push & ~full) begin
        wptr_q <= ptr_inc(wptr_q);
      end
      if (pop) begin
        rptr_q <= ptr_inc(rptr_q);
      end
      count_q <= count_q + {8'h00, push & ~full} - {8'h00, pop};
      err_cnt_q <= err_cnt_q + {8'h00, push & ~full & ent_bad(new_ent)}
                 - {8'h00, pop & ent_bad(head)};
    end
  end

  // ****************************************
  // Line status events
  // ****************************************
  // Overrun, sticky until line status read
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (push & full) begin
      overrun_q <= 1'b1;
    end else if (rd_lsr) begin
      overrun_q <= 1'b0;
    end
  end

  // Line status interrupt flag
  always_ff @(posedge clk) begin
    if (rst) begin
      ls_flag_q <= 1'b0;
    end else if ((push & (full | ent_bad(new_ent))) | (pop & head_bad_next)) begin
      ls_flag_q <= 1'b1;
    end else if (rd_lsr) begin
      ls_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_dis_q <= 1'b0;
    end else if (rx_dis_set) begin
      rx_dis_q <= 1'b1;
    end else if (rx_dis_clr) begin
      rx_dis_q <= 1'b0;
    end else if (wr_fire & (addr == UMD_OFS_MSR)) begin
      rx_dis_q <= wdata[UMD_MSR_RXDIS];
    end
  end

  // ****************************************
  // Modem and flow events
  // ****************************************
  // CTS pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      cts_sync_q <= 3'h7;
      cts_prev_q <= 1'b1;
      rts_prev_q <= 1'b1;
    end else if (ce) begin
      cts_sync_q <= {cts_sync_q[1:0], cts_n};
      if (cts_sync_q[1] == cts_sync_q[2]) begin
        cts_prev_q <= cts_sync_q[2];
      end
      rts_prev_q <= rts_n;
    end
  end

  // Sticky modem flags, read of modem status clears
  always_ff @(posedge clk) begin
    if (rst) begin
      delta_q <= '0;
      cts_flag_q <= 1'b0;
      rts_flag_q <= 1'b0;
    end else if (ce) begin
      delta_q <= (rd_msr ? 4'h0 : delta_q) | modem_delta;
      cts_flag_q <= (cts_flag_q & ~rd_msr)
                  | (~cts_prev_q & (cts_sync_q[1] == cts_sync_q[2]) & cts_sync_q[2]);
      rts_flag_q <= (rts_flag_q & ~rd_msr) | (~rts_prev_q & rts_n);
    end
  end

  assign xoff_event = rx_valid & ce & (rx_char.data == xoff1_q)
                    & ~(frac_q[UMD_FRAC_XPAR] & rx_char.par);

  // Xoff flag, event read clears
  always_ff @(posedge clk) begin
    if (rst) begin
      xoff_flag_q <= 1'b0;
    end else if (xoff_event) begin
      xoff_flag_q <= 1'b1;
    end else if (rd_evt) begin
      xoff_flag_q <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Software writes
  always_ff @(posedge clk) begin
    if (rst) begin
      div_low_q <= UMD_RST_BYTE;
      div_high_q <= UMD_RST_BYTE;
      frac_q <= UMD_RST_BYTE;
      imask_q <= UMD_RST_BYTE;
      lcr_q <= UMD_RST_BYTE;
      efr_q <= UMD_RST_BYTE;
      slave_q <= UMD_RST_BYTE;
      trig_q <= UMD_RST_TRIG;
      xoff1_q <= UMD_RST_BYTE;
      fifo_en_q <= 1'b0;
    end else if (wr_fire) begin
      unique case (addr)
        UMD_OFS_RHR: begin
          if (dlab) begin
            div_low_q <= wdata;
          end
        end
        UMD_OFS_IMASK: begin
          if (dlab) begin
            div_high_q <= wdata;
          end else if (efr_q[UMD_EFR_ENH]) begin
            imask_q <= wdata & ~UMD_IM_RSVD;
          end else begin
            imask_q <= {imask_q[7:5], 1'b0, wdata[3:0]};
          end
        end
        UMD_OFS_FCR: begin
          if (dlab) begin
            frac_q <= wdata;
          end else begin
            fifo_en_q <= wdata[UMD_FCR_EN];
          end
        end
        UMD_OFS_LCR: lcr_q <= wdata;
        UMD_OFS_EFR: efr_q <= wdata;
        UMD_OFS_SLAVE: slave_q <= wdata;
        UMD_OFS_TRIG: trig_q <= wdata;
        UMD_OFS_XOFF1: xoff1_q <= wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= UMD_RST_BYTE;
    end else if (rd_fire) begin
      unique case (addr)
        UMD_OFS_RHR: rdata <= dlab ? div_low_q : head.data;
        UMD_OFS_IMASK: rdata <= dlab ? div_high_q : imask_q;
        UMD_OFS_FCR: rdata <= dlab ? frac_q : {7'h00, fifo_en_q};
        UMD_OFS_LCR: rdata <= lcr_q;
        UMD_OFS_MSR: rdata <= {3'h0, rx_dis_q, delta_q};
        UMD_OFS_LSR: rdata <= {err_cnt_q != '0, tsr_empty & thr_empty, thr_empty,
                              ~empty & head.brk, ~empty & head.ferr,
                              ~empty & head.perr, overrun_q, ~empty};
        UMD_OFS_EFR: rdata <= efr_q;
        UMD_OFS_SLAVE: rdata <= slave_q;
        UMD_OFS_TRIG: rdata <= trig_q;
        UMD_OFS_EVT: rdata <= {4'h0, cts_flag_q, rts_flag_q, xoff_flag_q, ls_flag_q};
        UMD_OFS_XOFF1: rdata <= xoff1_q;
        default: rdata <= UMD_RST_BYTE;
      endcase
    end else if (ce) begin
      rdata <= UMD_RST_BYTE;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign baud_cfg.high = div_high_q;
  assign baud_cfg.low = div_low_q;
  assign baud_cfg.frac = frac_q[3:0];
  assign rs485_dir = tx_active ^ frac_q[UMD_FRAC_POL];
  assign ir_pulse_16ths = frac_q[UMD_FRAC_FIR] ? UMD_IR_FAST : UMD_IR_SLOW;
  assign polled_mode = fifo_en_q & (imask_q[3:0] == 4'h0);

  // Masked interrupt requests
  always_comb begin
    irq.line_status = imask_q[UMD_IM_LS] & ls_flag_q;
    irq.rx_ready = imask_q[UMD_IM_RX]
                 & (fifo_en_q ? (count_q >= {1'b0, trig_q}) : ~empty);
    irq.modem = imask_q[UMD_IM_MS] & (delta_q != 4'h0);
    irq.xoff = imask_q[UMD_IM_XOFF] & efr_q[UMD_EFR_ENH] & xoff_flag_q;
    irq.rts = imask_q[UMD_IM_RTS] & efr_q[UMD_EFR_ENH] & rts_flag_q;
    irq.cts = imask_q[UMD_IM_CTS] & efr_q[UMD_EFR_ENH] & cts_flag_q;
  end

endmodule

// [umd_rx_ctrl_chk.sv]
`timescale 1ns/1ps
// ********************************
// Port checker
// ********************************
module umd_rx_ctrl_chk
  import umd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic rx_valid,
  input wire logic tx_active,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic [3:0] modem_delta,
  input wire logic rs485_dir,
  input wire logic [3:0] ir_pulse_16ths,
  input wire logic xoff_event,
  input wire logic polled_mode,
  input wire umd_irq_t irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Status read with no arrival beside it
  sequence lsr_read_s;
    ce && rd && !wr && addr == UMD_OFS_LSR && !rx_valid;
  endsequence
  // Direction output tracks transmit activity
  dir_follow_a: assert property (
    !$past(rst) && !$past(wr) && $changed(tx_active) |-> $changed(rs485_dir))
    else $error("direction output missed transmit change");
  ir_width_a: assert property (
    ir_pulse_16ths == UMD_IR_SLOW || ir_pulse_16ths == UMD_IR_FAST)
    else $error("infrared width not three or four");
  polled_quiet_a: assert property (
    polled_mode |-> !irq.rx_ready && !irq.line_status && !irq.modem)
    else $error("interrupt raised in polled mode");
  xoff_cause_a: assert property (xoff_event |-> rx_valid && ce)
    else $error("xoff event without arrival");
  ls_cause_a: assert property (
    $rose(irq.line_status) && !$past(wr) |-> $past(rx_valid))
    else $error("line status irq without arrival");
  ls_clear_a: assert property (lsr_read_s |=> !irq.line_status)
    else $error("line status irq kept after status read");
  rxrdy_rise_a: assert property (
    $rose(irq.rx_ready) && !$past(wr) |-> $past(rx_valid))
    else $error("receive irq without arrival");
  rxrdy_fall_a: assert property ($fell(irq.rx_ready) |-> $past(rd) || $past(wr))
    else $error("receive irq dropped without read");
  modem_rise_a: assert property (
    $rose(irq.modem) && !$past(wr) |-> $past(|modem_delta))
    else $error("modem irq without delta");
  cts_rise_a: assert property (
    $rose(irq.cts) && !$past(wr) |-> $past(cts_n) && $past(cts_n, 2))
    else $error("cts irq without high pin");
  rts_rise_a: assert property ($rose(irq.rts) && !$past(wr) |-> $past(rts_n))
    else $error("rts irq without high output");
endmodule

bind umd_rx_ctrl umd_rx_ctrl_chk u_chk (
  .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr(wr), .rd(rd),
  .rx_valid(rx_valid), .tx_active(tx_active), .cts_n(cts_n), .rts_n(rts_n),
  .modem_delta(modem_delta), .rs485_dir(rs485_dir), .ir_pulse_16ths(ir_pulse_16ths),
  .xoff_event(xoff_event), .polled_mode(polled_mode), .irq(irq)
);

// [umd_station.sv]
`timescale 1ns/1ps
// ********************************
// Remote station on the line
// ********************************
module umd_station
  import umd_pkg::*;
(
  input wire logic clk,
  output umd_rx_char_t rx_char,
  output logic rx_valid
);
  // Idle line
  initial begin
    rx_valid = 1'b0;
    rx_char = '0;
  end
  task automatic send(input logic [7:0] d, input logic adr, input logic [1:0] err = 2'h0);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= umd_rx_char_t'({err, adr, d});
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= umd_rx_char_t'(~{err, adr, d});
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
// ********************************
// Bench top
// ********************************
module testbench;
  import umd_pkg::*;
  logic clk, rst, ce, wr, rd, thr_empty, tsr_empty, tx_active, cts_n, rts_n;
  logic rx_valid, rs485_dir, xoff_event, polled_mode;
  logic [3:0] addr, modem_delta, ir_pulse_16ths;
  logic [7:0] wdata, rdata;
  umd_rx_char_t rx_char;
  umd_baud_cfg_t baud_cfg;
  umd_irq_t irq;
  int mismatches = 0;
  int total_checks = 0;
  int xoff_seen = 0;

  // Counts flow character events
  always @(posedge clk) begin
    if (xoff_event === 1'b1) begin
      xoff_seen <= xoff_seen + 1;
    end
  end

  umd_station st (.clk(clk), .rx_char(rx_char), .rx_valid(rx_valid));
  umd_rx_ctrl DUT (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_char(rx_char),
    .thr_empty(thr_empty), .tsr_empty(tsr_empty), .tx_active(tx_active), .cts_n(cts_n),
    .rts_n(rts_n), .modem_delta(modem_delta), .baud_cfg(baud_cfg), .rs485_dir(rs485_dir),
    .ir_pulse_16ths(ir_pulse_16ths), .xoff_event(xoff_event), .polled_mode(polled_mode),
    .irq(irq));

  // Clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #2000000;
    mismatches++;
    print_verdict;
  end
  // Bus write, one cycle
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Bus read, data the cycle after
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Fraction and mode through the latch
  task automatic set_frac(input logic [7:0] d);
    wreg(UMD_OFS_LCR, 8'h80);
    wreg(UMD_OFS_FCR, d);
    wreg(UMD_OFS_LCR, 8'h38);
  endtask
  task automatic t_regs;
    do_reset;
    rchk(UMD_OFS_IMASK, 8'h00, "mask reset");
    rchk(UMD_OFS_TRIG, 8'h01, "trig reset");
    wreg(UMD_OFS_LCR, 8'h80);
    wreg(UMD_OFS_RHR, 8'h12);
    wreg(UMD_OFS_IMASK, 8'h34);
    wreg(UMD_OFS_FCR, 8'h95);
    #1;
    `CHK("baud", umd_baud_cfg_t'(20'h34125), baud_cfg)
    `CHK("ir fast", UMD_IR_FAST, ir_pulse_16ths)
    `CHK("dir rx", 1'b1, rs485_dir)
    @(posedge clk);
    tx_active <= 1'b1;
    wreg(UMD_OFS_LCR, 8'h00);
    wreg(UMD_OFS_IMASK, 8'hFF);
    #1;
    `CHK("dir tx", 1'b0, rs485_dir)
    `CHK("baud kept", umd_baud_cfg_t'(20'h34125), baud_cfg)
    rchk(UMD_OFS_IMASK, 8'h0F, "mask plain");
    wreg(UMD_OFS_EFR, 8'h10);
    wreg(UMD_OFS_IMASK, 8'hFF);
    rchk(UMD_OFS_IMASK, 8'hEF, "mask enh");
    set_frac(8'h00);
    #1;
    `CHK("ir slow", UMD_IR_SLOW, ir_pulse_16ths)
    `CHK("dir pol0", 1'b1, rs485_dir)
    @(posedge clk);
    tx_active <= 1'b0;
  endtask
  task automatic t_normal;
    do_reset;
    wreg(UMD_OFS_FCR, 8'h01);
    set_frac(8'h40);
    wreg(UMD_OFS_IMASK, 8'h04);
    wreg(UMD_OFS_MSR, 8'h04);
    st.send(8'h5A, 1'b0);
    rchk(UMD_OFS_LSR, 8'h60, "lsr drop");
    st.send(8'h21, 1'b1);
    #1;
    `CHK("ls irq", 1'b1, irq.line_status)
    rchk(UMD_OFS_LSR, 8'hE5, "lsr addr");
    rchk(UMD_OFS_RHR, 8'h21, "addr byte");
    wreg(UMD_OFS_MSR, 8'h00);
    st.send(8'h5A, 1'b0);
    rchk(UMD_OFS_RHR, 8'h5A, "data");
    st.send(8'h22, 1'b1);
    #1;
    `CHK("ls irq 2", 1'b1, irq.line_status)
  endtask
  task automatic t_auto;
    do_reset;
    wreg(UMD_OFS_FCR, 8'h01);
    set_frac(8'h40);
    wreg(UMD_OFS_EFR, 8'h20);
    wreg(UMD_OFS_SLAVE, 8'h42);
    wreg(UMD_OFS_IMASK, 8'h04);
    wreg(UMD_OFS_MSR, 8'h04);
    st.send(8'h11, 1'b0);
    st.send(8'h43, 1'b1);
    rchk(UMD_OFS_LSR, 8'h60, "lsr none");
    st.send(8'h42, 1'b1);
    #1;
    `CHK("ls match", 1'b1, irq.line_status)
    rchk(UMD_OFS_LSR, 8'hE5, "lsr match");
    st.send(8'h33, 1'b0);
    st.send(8'h55, 1'b1);
    st.send(8'h66, 1'b0);
    rchk(UMD_OFS_RHR, 8'h42, "match byte");
    rchk(UMD_OFS_LSR, 8'h61, "lsr one");
    rchk(UMD_OFS_RHR, 8'h33, "sel data");
    rchk(UMD_OFS_LSR, 8'h60, "lsr dropped");
  endtask
  task automatic t_fifo;
    do_reset;
    wreg(UMD_OFS_FCR, 8'h01);
    wreg(UMD_OFS_TRIG, 8'h02);
    #1;
    `CHK("polled", 1'b1, polled_mode)
    wreg(UMD_OFS_IMASK, 8'h01);
    st.send(8'hA1, 1'b0);
    #1;
    `CHK("not polled", 1'b0, polled_mode)
    `CHK("rx below", 1'b0, irq.rx_ready)
    rchk(UMD_OFS_LSR, 8'h61, "lsr ready");
    st.send(8'hA2, 1'b0);
    #1;
    `CHK("rx at trig", 1'b1, irq.rx_ready)
    rchk(UMD_OFS_RHR, 8'hA1, "pop one");
    `CHK("rx dropped", 1'b0, irq.rx_ready)
    rchk(UMD_OFS_RHR, 8'hA2, "pop two");
    rchk(UMD_OFS_LSR, 8'h60, "lsr empty");
    wreg(UMD_OFS_FCR, 8'h00);
    thr_empty <= 1'b0;
    tsr_empty <= 1'b0;
    st.send(8'hB1, 1'b0);
    st.send(8'hB2, 1'b0);
    rchk(UMD_OFS_LSR, 8'h03, "lsr overrun");
    @(posedge clk);
    thr_empty <= 1'b1;
    tsr_empty <= 1'b1;
    rchk(UMD_OFS_RHR, 8'hB1, "pop kept");
    st.send(8'hC3, 1'b0, 2'h3);
    rchk(UMD_OFS_LSR, 8'hF9, "lsr errors");
  endtask
  task automatic t_irq;
    int n0;
    do_reset;
    n0 = xoff_seen;
    wreg(UMD_OFS_EFR, 8'h10);
    wreg(UMD_OFS_IMASK, 8'hE8);
    wreg(UMD_OFS_XOFF1, 8'h13);
    set_frac(8'h20);
    st.send(8'h13, 1'b1);
    #1;
    `CHK("xoff perr", 1'b0, irq.xoff)
    st.send(8'h13, 1'b0);
    #1;
    `CHK("xoff", 1'b1, irq.xoff)
    @(posedge clk);
    cts_n <= 1'b1;
    rts_n <= 1'b1;
    modem_delta <= 4'h2;
    @(posedge clk);
    modem_delta <= 4'h0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("cts", 1'b1, irq.cts)
    `CHK("rts", 1'b1, irq.rts)
    `CHK("modem", 1'b1, irq.modem)
    rchk(UMD_OFS_MSR, 8'h02, "msr deltas");
    `CHK("cts clr", 1'b0, irq.cts)
    `CHK("rts clr", 1'b0, irq.rts)
    `CHK("modem clr", 1'b0, irq.modem)
    rchk(UMD_OFS_EVT, 8'h03, "events");
    `CHK("xoff clr", 1'b0, irq.xoff)
    set_frac(8'h00);
    st.send(8'h13, 1'b1);
    #1;
    `CHK("xoff no check", 1'b1, irq.xoff)
    `CHK("xoff count", 2, xoff_seen - n0)
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    thr_empty = 1'b1;
    tsr_empty = 1'b1;
    tx_active = 1'b0;
    cts_n = 1'b0;
    rts_n = 1'b0;
    modem_delta = 4'h0;
    t_regs;
    t_normal;
    t_auto;
    t_fifo;
    t_irq;
    print_verdict;
  end
endmodule
